// ===== hw/sipo_pkg.sv
// Constants shared by the serial-in parallel-out shift register and its FIFO.
// Assumes a single 50 MHz clock domain.
package sipo_pkg;
    localparam int unsigned      SIPO_STAGES     = 8;
    localparam int unsigned      SIPO_FIFO_DEPTH = 8;
    localparam int unsigned      SIPO_FIFO_WIDTH = 1;
    localparam logic [7:0]       SIPO_STAGE_RST  = 8'h00;
    localparam logic             SIPO_SYNC_RST   = 1'h0;
    localparam logic             SIPO_CLR_IDLE   = 1'h1;
endpackage

// ===== hw/sipo_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes write and read sides share clk; entries are held in flip-flops.
`timescale 1ns/1ps
module sipo_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             flush,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    nxt_wr_ptr;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW-1:0]    nxt_rd_ptr;
    logic [CW-1:0]    count_ff;
    logic [CW-1:0]    nxt_count;
    logic             do_wr;
    logic             do_rd;

    assign wr_ready = (count_ff != CW'(DEPTH)) && !flush;
    assign rd_valid = (count_ff != '0) && !flush;
    assign rd_data  = mem_ff[rd_ptr_ff];
    assign do_wr    = wr_valid && wr_ready;
    assign do_rd    = rd_valid && rd_ready;

    always_comb begin
        nxt_mem    = mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_count  = count_ff;
        if (flush) begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_count  = '0;
        end else begin
            if (do_wr) begin
                nxt_mem[wr_ptr_ff] = wr_data;
                nxt_wr_ptr = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
            end
            if (do_rd) begin
                nxt_rd_ptr = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + PW'(1);
            end
            case ({do_wr, do_rd})
                2'b10:   nxt_count = count_ff + CW'(1);
                2'b01:   nxt_count = count_ff - CW'(1);
                default: nxt_count = count_ff;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_ff    <= '{default: '0};
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            mem_ff    <= nxt_mem;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
        end
    end
endmodule

// ===== hw/sipo_shift_reg.sv
// Eight-stage serial-in parallel-out shift register sampled on clk.
// Assumes shift_clock, clear_n and the serial inputs are asynchronous pins.
// Summary of operation
// - Eight stages, each drives its own output
// - Rising shift clock moves each stage onward
// - First stage loads AND of serial inputs
// - Either serial input gates the other one
// - Low clear forces all stages low immediately
// - Shift uses values sampled together with the edge
`timescale 1ns/1ps
module sipo_shift_reg
    import sipo_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   shift_clock,
    input  wire logic                   clear_n,
    input  wire logic                   ser_in_a,
    input  wire logic                   ser_in_b,
    output logic [SIPO_STAGES-1:0]      stage_outputs,
    output logic                        in_ready
);
    logic                   clr_arst_b;
    logic                   clr_sync1_ff;
    logic                   clr_sync2_ff;
    logic                   clear_active;
    logic [2:0]             clk_sync_ff;
    logic [2:0]             nxt_clk_sync;
    logic [1:0]             a_sync_ff;
    logic [1:0]             nxt_a_sync;
    logic [1:0]             b_sync_ff;
    logic [1:0]             nxt_b_sync;
    logic                   shift_edge;
    logic                   entry_bit;
    logic                   fifo_valid;
    logic                   fifo_bit;
    logic [SIPO_STAGES-1:0] stage_ff;
    logic [SIPO_STAGES-1:0] nxt_stage;

    // Clear asserts at once through the reset pin; release is synchronised
    assign clr_arst_b = rst_b & clear_n;

    always_ff @(posedge clk or negedge clr_arst_b) begin
        if (!clr_arst_b) begin
            clr_sync1_ff <= SIPO_SYNC_RST;
            clr_sync2_ff <= SIPO_SYNC_RST;
        end else begin
            clr_sync1_ff <= SIPO_CLR_IDLE;
            clr_sync2_ff <= clr_sync1_ff;
        end
    end

    assign clear_active = !clr_sync2_ff;

    // Clock takes three flops and data two; data stage 1 lines up with the clock sample that marks its edge
    always_comb begin
        nxt_clk_sync = {clk_sync_ff[1:0], shift_clock};
        nxt_a_sync   = {a_sync_ff[0], ser_in_a};
        nxt_b_sync   = {b_sync_ff[0], ser_in_b};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_sync_ff <= '0;
            a_sync_ff   <= '0;
            b_sync_ff   <= '0;
        end else begin
            clk_sync_ff <= nxt_clk_sync;
            a_sync_ff   <= nxt_a_sync;
            b_sync_ff   <= nxt_b_sync;
        end
    end

    assign shift_edge = clk_sync_ff[1] && !clk_sync_ff[2] && !clear_active;
    assign entry_bit  = a_sync_ff[1] & b_sync_ff[1];

    sipo_fifo #(
        .WIDTH (SIPO_FIFO_WIDTH),
        .DEPTH (SIPO_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_b    (rst_b),
        .flush    (clear_active),
        .wr_valid (shift_edge),
        .wr_ready (in_ready),
        .wr_data  (entry_bit),
        .rd_valid (fifo_valid),
        .rd_ready (!clear_active),
        .rd_data  (fifo_bit)
    );

    always_comb begin
        nxt_stage = stage_ff;
        if (fifo_valid) begin
            nxt_stage = {stage_ff[SIPO_STAGES-2:0], fifo_bit};
        end
    end

    always_ff @(posedge clk or negedge clr_arst_b) begin
        if (!clr_arst_b) begin
            stage_ff <= SIPO_STAGE_RST;
        end else begin
            stage_ff <= nxt_stage;
        end
    end

    assign stage_outputs = stage_ff;
endmodule

// ===== verif/sipo_shift_reg_props.sv
// Concurrent checks on the shift register ports.
// Assumes pins held for three clk cycles per level, as the driver model does.
`timescale 1ns/1ps
module sipo_shift_reg_props
    import sipo_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire logic                   shift_clock,
    input wire logic                   clear_n,
    input wire logic                   ser_in_a,
    input wire logic                   ser_in_b,
    input wire logic [SIPO_STAGES-1:0] stage_outputs,
    input wire logic                   in_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_clear_zero: assert property (!clear_n |-> stage_outputs == 8'h00)
        else $error("stages not cleared");
    a_clear_unready: assert property (!clear_n |-> !in_ready)
        else $error("ready during clear");
    a_release_zero: assert property ($rose(clear_n) |-> (stage_outputs == 8'h00)[*2])
        else $error("stages moved at clear release");
    a_ready_after: assert property ($rose(clear_n) |-> ##[1:4] in_ready)
        else $error("ready late after clear");
    a_shift_moves: assert property ($changed(stage_outputs) && clear_n && $past(clear_n)
        |-> stage_outputs[7:1] == $past(stage_outputs[6:0])) else $error("bad shift");
    a_first_and: assert property ($changed(stage_outputs) && clear_n && $past(clear_n)
        |-> stage_outputs[0] == ($past(ser_in_a, 2) & $past(ser_in_b, 2)))
        else $error("first stage not AND of inputs");
    a_shift_edge: assert property ($changed(stage_outputs) && clear_n |-> $past(shift_clock, 2))
        else $error("shift without edge");
    a_hold_idle: assert property ((clear_n && $stable(shift_clock))[*6] |=> !clear_n || $stable(stage_outputs))
        else $error("stages changed while idle");
    cover property ($rose(shift_clock) && in_ready);
    cover property ($fell(clear_n));
    cover property (stage_outputs[7]);
endmodule
bind sipo_shift_reg sipo_shift_reg_props i_props (.clk(clk), .rst_b(rst_b),
    .shift_clock(shift_clock), .clear_n(clear_n), .ser_in_a(ser_in_a),
    .ser_in_b(ser_in_b), .stage_outputs(stage_outputs), .in_ready(in_ready));

// ===== verif/sipo_drv.sv
// Driving logic model: serial data, shift clock and clear pins.
// Assumes a free-running clk; every pin moves 1 ns after a rising edge.
`timescale 1ns/1ps
module sipo_drv (
    input wire logic clk,
    output logic     shift_clock,
    output logic     clear_n,
    output logic     ser_in_a,
    output logic     ser_in_b
);
    initial begin
        shift_clock = 1'h0;
        clear_n     = 1'h1;
        ser_in_a    = 1'h1;
        ser_in_b    = 1'h1;
    end
    // Three cycles high, three low; data then flips so stale data shows
    task automatic shift(input logic a, input logic b);
        @(posedge clk) #1;
        ser_in_a = a;
        ser_in_b = b;
        shift_clock = 1'h1;
        repeat (3) @(posedge clk);
        #1 shift_clock = 1'h0;
        repeat (3) @(posedge clk);
        #1 ser_in_a = ~a;
        ser_in_b = ~b;
    endtask
    task automatic clr(input logic v);
        @(posedge clk) #1 clear_n = v;
    endtask
endmodule

// ===== verif/tb_sipo_shift_reg.sv
// Self-checking bench for the shift register.
// Assumes the driver model in sipo_drv and the bound checker.
`timescale 1ns/1ps
module tb_sipo_shift_reg;
    import sipo_pkg::*;
    logic                   clk;
    logic                   rst_b;
    logic                   shift_clock;
    logic                   clear_n;
    logic                   ser_in_a;
    logic                   ser_in_b;
    logic [SIPO_STAGES-1:0] stage_outputs;
    logic                   in_ready;
    logic [7:0]             exp;
    int                     error_cnt;
    int                     checks_done;
    sipo_drv i_drv (.clk(clk), .shift_clock(shift_clock), .clear_n(clear_n),
        .ser_in_a(ser_in_a), .ser_in_b(ser_in_b));
    sipo_shift_reg i_dut (.clk(clk), .rst_b(rst_b), .shift_clock(shift_clock),
        .clear_n(clear_n), .ser_in_a(ser_in_a), .ser_in_b(ser_in_b),
        .stage_outputs(stage_outputs), .in_ready(in_ready));
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [7:0] e);
        checks_done++;
        if (stage_outputs !== e) begin
            error_cnt++;
            $display("CHECK FAILED stage_outputs exp %h got %h", e, stage_outputs);
        end
    endtask
    task automatic chk_rdy(input logic e);
        checks_done++;
        if (in_ready !== e) begin
            error_cnt++;
            $display("CHECK FAILED in_ready exp %h got %h", e, in_ready);
        end
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // All four input pairs, enough shifts to reach the last stage
    task automatic t_shift;
        logic [23:0] pat;
        pat = 24'hFCE4FF;
        for (int i = 0; i < 12; i++) begin
            exp = {exp[6:0], pat[23-2*i] & pat[22-2*i]};
            i_drv.shift(pat[23-2*i], pat[22-2*i]);
            chk(exp);
        end
        repeat (20) @(posedge clk);
        chk(exp);
    endtask
    // Clear mid-run, shift attempt while cleared, then shift after release
    task automatic t_clear;
        i_drv.clr(1'h0);
        #1 chk(8'h00);
        chk_rdy(1'h0);
        i_drv.shift(1'h1, 1'h1);
        chk(8'h00);
        i_drv.clr(1'h1);
        repeat (4) @(posedge clk);
        chk_rdy(1'h1);
        i_drv.shift(1'h1, 1'h1);
        chk(8'h01);
    endtask
    initial begin
        rst_b = 1'h0;
        exp = 8'h00;
        error_cnt = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'h1;
        repeat (5) @(posedge clk);
        t_shift();
        t_clear();
        end_of_test();
    end
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end
endmodule
